// [hw/bstap_consts.svh]
// Overview of operation
// - TAP state machine follows standard 1149.1
// - Sample on TCK rise, drive TDO on fall
// - TDI enters MSB, TDO shows LSB
// - TDO driven only in Shift-IR/Shift-DR
// - One register between TDI and TDO
// - Five TMS-high TCK rises reset the TAP
// - Power-up reset leaves TDO high impedance
// - IR updates in Update-IR; resets to IDCODE
// - Capture-IR loads 01 into low bits
// - Lengths: IR 8, bypass 1, BSR 113, ID 32
// - Bypass bit captures zero
// - BSR captures ring, shifts in Shift-DR
// - IDCODE captures hardwired 32-bit value
// - TDI and TMS float high, TAP inert
// - Impedance mode bit cleared at power-up
// - High-Z: bypass path, memory outputs tri-stated
// - CLAMP: balls driven from BSR, bypass path
// - SAMPLE/PRELOAD captures ball snapshot into BSR
// - EXTEST: drivers on, preloaded values driven
`ifndef BSTAP_CONSTS_SVH
`define BSTAP_CONSTS_SVH
`define BSTAP_IR_LEN      8
`define BSTAP_BSR_LEN     113
`define BSTAP_ID_LEN      32
`define BSTAP_OP_EXTEST   8'h00
`define BSTAP_OP_IDCODE   8'h21
`define BSTAP_OP_SAMPLE   8'h05
`define BSTAP_OP_CLAMP    8'h07
`define BSTAP_OP_HIGHZ    8'h03
`define BSTAP_OP_BYPASS   8'hff
`define BSTAP_IR_CAPTURE  8'h01
`define BSTAP_PIN_RESET   3'h3
`endif

// [hw/bstap_pkg.sv]
package bstap_pkg;
	typedef enum logic [3:0]
	{
		BSTAP_TLR     = 4'h0,
		BSTAP_IDLE    = 4'h1,
		BSTAP_SEL_DR  = 4'h3,
		BSTAP_CAP_DR  = 4'h2,
		BSTAP_SH_DR   = 4'h6,
		BSTAP_EX1_DR  = 4'h7,
		BSTAP_PAU_DR  = 4'h5,
		BSTAP_EX2_DR  = 4'h4,
		BSTAP_UPD_DR  = 4'hc,
		BSTAP_SEL_IR  = 4'hd,
		BSTAP_CAP_IR  = 4'hf,
		BSTAP_SH_IR   = 4'he,
		BSTAP_EX1_IR  = 4'ha,
		BSTAP_PAU_IR  = 4'hb,
		BSTAP_EX2_IR  = 4'h9,
		BSTAP_UPD_IR  = 4'h8
	} bstap_state_e;

	typedef enum logic [1:0]
	{
		BSTAP_PATH_BYPASS = 2'h0,
		BSTAP_PATH_BSR    = 2'h1,
		BSTAP_PATH_ID     = 2'h2
	} bstap_path_e;

	// Pin order: tck, tms, tdi
	typedef struct packed
	{
		logic tck;
		logic tms;
		logic tdi;
	} bstap_pins_s;

	typedef struct packed
	{
		logic         drive_en;
		logic         force_hiz;
		logic [112:0] values;
	} bstap_ring_s;
endpackage

// [hw/bstap_sync.sv]
`timescale 1ns/1ns
module bstap_sync
#(
	parameter int        W   = 3,
	parameter logic [W-1:0] RST = '0
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Asynchronous in, synchronous out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					meta_reg[i] <= RST[i];
					q[i]        <= RST[i];
				end
				else
				begin
					meta_reg[i] <= d[i];
					q[i]        <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule

// [hw/bstap_top.sv]
`timescale 1ns/1ns
`include "bstap_consts.svh"
module bstap_top
	import bstap_pkg::*;
#(
	// Arbitrary identification value; bit 0 marks presence of the ID register
	parameter logic [31:0] ID_VALUE = 32'h1a5c_3e2b
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Test port pins
	input  wire bstap_pins_s  pins,
	output logic              tdo,
	output logic              tdo_oe_n,
	// Memory I/O ring
	input  wire logic [112:0] ring_in,
	output bstap_ring_s       ring_ctl,
	// Mode register interaction
	input  wire logic         mode_register_write,
	input  wire logic         mr_impedance_bit,
	output logic              impedance_mode_bit
);
	bstap_pins_s  pins_s;
	logic         tck_d_reg;
	logic         tck_rise;
	logic         tck_fall;
	bstap_state_e state_reg;
	bstap_state_e state_next;
	logic [7:0]   ir_reg;
	logic [7:0]   ir_sh_reg;
	logic         bypass_reg;
	logic [112:0] bsr_reg;
	logic [31:0]  id_reg;
	bstap_path_e  path;
	logic         dr_lsb;

	// Idle pin levels: clock low, pulled-up pins high; no false edge on release
	bstap_sync #(.W(3), .RST(`BSTAP_PIN_RESET)) u_sync
	(
		.clk   (clk),
		.reset (reset),
		.d     (pins),
		.q     (pins_s)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
			tck_d_reg <= 1'b0;
		else
			tck_d_reg <= pins_s.tck;
	end

	assign tck_rise = pins_s.tck & ~tck_d_reg;
	assign tck_fall = ~pins_s.tck & tck_d_reg;

	// Standard controller graph
	always_comb
	begin
		case (state_reg)
			BSTAP_TLR:    state_next = pins_s.tms ? BSTAP_TLR : BSTAP_IDLE;
			BSTAP_IDLE:   state_next = pins_s.tms ? BSTAP_SEL_DR : BSTAP_IDLE;
			BSTAP_SEL_DR: state_next = pins_s.tms ? BSTAP_SEL_IR : BSTAP_CAP_DR;
			BSTAP_CAP_DR: state_next = pins_s.tms ? BSTAP_EX1_DR : BSTAP_SH_DR;
			BSTAP_SH_DR:  state_next = pins_s.tms ? BSTAP_EX1_DR : BSTAP_SH_DR;
			BSTAP_EX1_DR: state_next = pins_s.tms ? BSTAP_UPD_DR : BSTAP_PAU_DR;
			BSTAP_PAU_DR: state_next = pins_s.tms ? BSTAP_EX2_DR : BSTAP_PAU_DR;
			BSTAP_EX2_DR: state_next = pins_s.tms ? BSTAP_UPD_DR : BSTAP_SH_DR;
			BSTAP_UPD_DR: state_next = pins_s.tms ? BSTAP_SEL_DR : BSTAP_IDLE;
			BSTAP_SEL_IR: state_next = pins_s.tms ? BSTAP_TLR : BSTAP_CAP_IR;
			BSTAP_CAP_IR: state_next = pins_s.tms ? BSTAP_EX1_IR : BSTAP_SH_IR;
			BSTAP_SH_IR:  state_next = pins_s.tms ? BSTAP_EX1_IR : BSTAP_SH_IR;
			BSTAP_EX1_IR: state_next = pins_s.tms ? BSTAP_UPD_IR : BSTAP_PAU_IR;
			BSTAP_PAU_IR: state_next = pins_s.tms ? BSTAP_EX2_IR : BSTAP_PAU_IR;
			BSTAP_EX2_IR: state_next = pins_s.tms ? BSTAP_UPD_IR : BSTAP_SH_IR;
			BSTAP_UPD_IR: state_next = pins_s.tms ? BSTAP_SEL_DR : BSTAP_IDLE;
			default:      state_next = BSTAP_TLR;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state_reg <= BSTAP_TLR;
		else if (tck_rise)
			state_reg <= state_next;
	end

	// Instruction path
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ir_reg    <= `BSTAP_OP_IDCODE;
			ir_sh_reg <= `BSTAP_IR_CAPTURE;
		end
		// Entering reset loads IDCODE on the rise that enters it, a rise sooner than Update-IR loads
		else if (tck_rise && state_next == BSTAP_TLR)
			ir_reg <= `BSTAP_OP_IDCODE;
		else if (tck_rise)
		begin
			case (state_reg)
				BSTAP_CAP_IR: ir_sh_reg <= `BSTAP_IR_CAPTURE;
				BSTAP_SH_IR:  ir_sh_reg <= {pins_s.tdi, ir_sh_reg[7:1]};
				BSTAP_UPD_IR: ir_reg    <= ir_sh_reg;
				default:      ir_reg    <= ir_reg;
			endcase
		end
	end

	// One data register per instruction; unknown codes fall to bypass
	always_comb
	begin
		case (ir_reg)
			`BSTAP_OP_EXTEST: path = BSTAP_PATH_BSR;
			`BSTAP_OP_SAMPLE: path = BSTAP_PATH_BSR;
			`BSTAP_OP_IDCODE: path = BSTAP_PATH_ID;
			`BSTAP_OP_CLAMP:  path = BSTAP_PATH_BYPASS;
			`BSTAP_OP_HIGHZ:  path = BSTAP_PATH_BYPASS;
			default:          path = BSTAP_PATH_BYPASS;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			bypass_reg <= 1'b0;
		else if (tck_rise && path == BSTAP_PATH_BYPASS)
		begin
			if (state_reg == BSTAP_CAP_DR)
				bypass_reg <= 1'b0;
			else if (state_reg == BSTAP_SH_DR)
				bypass_reg <= pins_s.tdi;
		end
	end

	// Ring is sampled as-is; a ball moving at capture may read either way
	always_ff @(posedge clk)
	begin
		if (reset)
			bsr_reg <= '0;
		else if (tck_rise && path == BSTAP_PATH_BSR)
		begin
			if (state_reg == BSTAP_CAP_DR)
				bsr_reg <= ring_in;
			else if (state_reg == BSTAP_SH_DR)
				bsr_reg <= {pins_s.tdi, bsr_reg[112:1]};
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			id_reg <= ID_VALUE;
		else if (tck_rise && path == BSTAP_PATH_ID)
		begin
			if (state_reg == BSTAP_CAP_DR)
				id_reg <= ID_VALUE;
			else if (state_reg == BSTAP_SH_DR)
				id_reg <= {pins_s.tdi, id_reg[31:1]};
		end
	end

	// Preloaded values reach the balls only on Update-DR
	always_ff @(posedge clk)
	begin
		if (reset)
			ring_ctl.values <= '0;
		else if (tck_rise && state_reg == BSTAP_UPD_DR && path == BSTAP_PATH_BSR)
			ring_ctl.values <= bsr_reg;
	end

	// Test takes the balls only under EXTEST, CLAMP or High-Z
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ring_ctl.drive_en  <= 1'b0;
			ring_ctl.force_hiz <= 1'b0;
		end
		else
		begin
			ring_ctl.drive_en  <= ir_reg == `BSTAP_OP_EXTEST || ir_reg == `BSTAP_OP_CLAMP;
			ring_ctl.force_hiz <= ir_reg == `BSTAP_OP_HIGHZ;
		end
	end

	always_comb
	begin
		case (path)
			BSTAP_PATH_BSR: dr_lsb = bsr_reg[0];
			BSTAP_PATH_ID:  dr_lsb = id_reg[0];
			default:        dr_lsb = bypass_reg;
		endcase
	end

	// Output moves on the falling edge, half a test clock after the shift
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tdo      <= 1'b0;
			tdo_oe_n <= 1'b1;
		end
		else if (tck_fall)
		begin
			tdo      <= state_reg == BSTAP_SH_IR ? ir_sh_reg[0] : dr_lsb;
			tdo_oe_n <= !(state_reg == BSTAP_SH_IR || state_reg == BSTAP_SH_DR);
		end
	end

	// Bit mirrors the memory's mode register; boundary test needs it low
	always_ff @(posedge clk)
	begin
		if (reset)
			impedance_mode_bit <= 1'b0;
		else if (mode_register_write)
			impedance_mode_bit <= mr_impedance_bit;
	end
endmodule

// [sim/bstap_ctl_model.sv]
`timescale 1ns/1ns
module bstap_ctl_model
	import bstap_pkg::*;
(
	// Clock
	input wire logic  clk,
	// Test port
	output bstap_pins_s pins,
	input wire logic  tdo,
	input wire logic  tdo_oe_n,
	// Bit read back
	output logic      seen,
	output logic      seen_v
);
	initial
	begin
		pins = 3'b011;
		seen = 1'b0;
		seen_v = 1'b0;
	end
	// One 160 ns period; TDO read just before the rise
	task automatic step(input logic m, input logic d, input logic c);
		@(posedge clk);
		pins <= '{tck: 1'b0, tms: m, tdi: d};
		repeat (8) @(posedge clk);
		seen <= tdo_oe_n ? 1'bx : tdo;
		seen_v <= c;
		pins.tck <= 1'b1;
		@(posedge clk);
		seen_v <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
endmodule

// [sim/bstap_top_props.sv]
`timescale 1ns/1ns
module bstap_props
	import bstap_pkg::*;
(
	// Clock and reset
	input wire logic         clk,
	input wire logic         reset,
	// Watched ports
	input wire bstap_pins_s  pins,
	input wire logic         tdo,
	input wire logic         tdo_oe_n,
	input wire logic [112:0] ring_in,
	input wire bstap_ring_s  ring_ctl,
	input wire logic         mode_register_write,
	input wire logic         mr_impedance_bit,
	input wire logic         impedance_mode_bit
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [2:0] ones_reg;
	// TCK rises seen with TMS high
	always_ff @(posedge clk)
	begin
		if (reset)
			ones_reg <= 3'h0;
		else if ($rose(pins.tck))
			ones_reg <= pins.tms ? ones_reg + {2'h0, ones_reg != 3'h7} : 3'h0;
	end
	chk_reset_quiet:
	assert property (disable iff (1'b0) reset |=> tdo_oe_n && ring_ctl == '0) else $error("reset");
	chk_mode_copy:
	assert property (mode_register_write |=> impedance_mode_bit == $past(mr_impedance_bit))
		else $error("mode copy");
	chk_mode_hold:
	assert property (!mode_register_write |=> $stable(impedance_mode_bit)) else $error("mode hold");
	chk_tdo_fall:
	assert property (!$stable({tdo, tdo_oe_n}) |-> !$past(pins.tck, 3)) else $error("tdo edge");
	chk_ring_rise:
	assert property (!$stable(ring_ctl.values) |-> $past(pins.tck, 3)) else $error("ring edge");
	chk_flag_rise:
	assert property (!$stable({ring_ctl.drive_en, ring_ctl.force_hiz}) |-> $past(pins.tck, 4))
		else $error("flag edge");
	chk_flag_apart:
	assert property (!(ring_ctl.drive_en && ring_ctl.force_hiz)) else $error("flags");
	chk_oe_holds:
	assert property ($fell(tdo_oe_n) |-> !tdo_oe_n [*6]) else $error("oe short");
	chk_tms_reset:
	assert property ($rose(ones_reg == 3'h5) |-> ##8 tdo_oe_n && !ring_ctl.drive_en
		&& !ring_ctl.force_hiz) else $error("tms reset");
	cov_shift: cover property ($fell(tdo_oe_n));
	cov_hiz: cover property (ring_ctl.force_hiz);
	cov_drive: cover property (ring_ctl.drive_en);
endmodule
bind bstap_top bstap_props i_props (.clk, .reset, .pins, .tdo, .tdo_oe_n, .ring_in, .ring_ctl,
	.mode_register_write, .mr_impedance_bit, .impedance_mode_bit);

// [sim/bstap_top_tb.sv]
`timescale 1ns/1ns
`include "bstap_consts.svh"
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin err_total++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module bstap_top_tb
	import bstap_pkg::*;
;
	localparam logic [31:0] ID = 32'h1a5c_3e2b; // Arbitrary value
	logic         clk, reset, tdo, tdo_oe_n, seen, seen_v, ev;
	logic         mode_register_write, mr_impedance_bit, impedance_mode_bit;
	logic [112:0] ring_in, pat;
	logic [127:0] w;
	logic [31:0]  rs = 32'hf6cb;
	logic [7:0]   ops[4] = '{`BSTAP_OP_BYPASS, 8'h5a, `BSTAP_OP_CLAMP, `BSTAP_OP_HIGHZ};
	logic         q[$];
	int           err_total, tests_run, cyc;
	bstap_pins_s  pins;
	bstap_ring_s  ring_ctl;
	bstap_top #(.ID_VALUE(ID)) i_dut (.clk, .reset, .pins, .tdo, .tdo_oe_n, .ring_in, .ring_ctl,
		.mode_register_write, .mr_impedance_bit, .impedance_mode_bit);
	bstap_ctl_model i_ctl (.clk, .pins, .tdo, .tdo_oe_n, .seen, .seen_v);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [112:0] rnd4();
		for (int i = 0; i < 4; i++)
		begin
			rs = rs ^ (rs << 13);
			rs = rs ^ (rs >> 17);
			rs = rs ^ (rs << 5);
			w = {w[95:0], rs};
		end
		return w[112:0];
	endfunction
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// From idle through one scan and back to idle
	task automatic scan(input logic ir, input int n, input logic [112:0] d, input logic [112:0] e);
		i_ctl.step(1'b1, 1'b1, 1'b0);
		if (ir)
			i_ctl.step(1'b1, 1'b1, 1'b0);
		i_ctl.step(1'b0, 1'b1, 1'b0);
		i_ctl.step(1'b0, 1'b1, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			q.push_back(e[i]);
			i_ctl.step(i == n - 1, d[i], 1'b1);
		end
		i_ctl.step(1'b1, 1'b1, 1'b0);
		i_ctl.step(1'b0, 1'b1, 1'b0);
		`CHK("oe_n", 1'b1, tdo_oe_n)
	endtask
	task automatic mrw(input logic v);
		@(posedge clk);
		mode_register_write <= 1'b1;
		mr_impedance_bit <= v;
		@(posedge clk);
		mode_register_write <= 1'b0;
		@(negedge clk);
		`CHK("imp", v, impedance_mode_bit)
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			results();
		end
		if (seen_v)
		begin
			ev = q.pop_front();
			`CHK("tdo", ev, seen)
		end
	end
	initial
	begin
		reset = 1'b1;
		mode_register_write = 1'b0;
		mr_impedance_bit = 1'b0;
		ring_in = '0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		`CHK("oe_n", 1'b1, tdo_oe_n)
		`CHK("imp", 1'b0, impedance_mode_bit)
		mrw(1'b1);
		mrw(1'b0);
		$display("test mode done");
		i_ctl.step(1'b0, 1'b1, 1'b0);
		scan(1'b0, 32, rnd4(), {81'h0, ID});
		$display("test idcode done");
		@(posedge clk);
		ring_in <= rnd4();
		pat = rnd4();
		@(posedge clk);
		scan(1'b1, 8, {105'h0, `BSTAP_OP_SAMPLE}, {105'h0, `BSTAP_IR_CAPTURE});
		scan(1'b0, 113, pat, ring_in);
		`CHK("vals", pat, ring_ctl.values)
		scan(1'b1, 8, {105'h0, `BSTAP_OP_EXTEST}, {105'h0, `BSTAP_IR_CAPTURE});
		`CHK("drive", 1'b1, ring_ctl.drive_en)
		`CHK("vals", pat, ring_ctl.values)
		$display("test ring done");
		foreach (ops[k])
		begin
			scan(1'b1, 8, {105'h0, ops[k]}, {105'h0, `BSTAP_IR_CAPTURE});
			`CHK("drive", ops[k] == `BSTAP_OP_CLAMP, ring_ctl.drive_en)
			`CHK("hiz", ops[k] == `BSTAP_OP_HIGHZ, ring_ctl.force_hiz)
			pat = rnd4();
			scan(1'b0, 16, pat, {pat[111:0], 1'b0});
		end
		$display("test bypass done");
		repeat (5) i_ctl.step(1'b1, 1'b1, 1'b0);
		`CHK("hiz", 1'b0, ring_ctl.force_hiz)
		i_ctl.step(1'b0, 1'b1, 1'b0);
		scan(1'b0, 32, '0, {81'h0, ID});
		$display("test tms_reset done");
		results();
	end
endmodule
